// file: design/dupf_pkg.sv
// package: offsets, field positions and reset values of the pin function block
package dupf_pkg;
    // ==========================================================
    // register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_OUT_PORT_CONFIG = 8'h00;
    localparam logic [7:0] OFS_OUT_PORT_DATA   = 8'h04;
    localparam logic [7:0] OFS_OUT_PORT_SET    = 8'h08;
    localparam logic [7:0] OFS_OUT_PORT_CLEAR  = 8'h0c;
    localparam logic [7:0] OFS_IN_PORT         = 8'h10;
    localparam logic [7:0] OFS_FUNC_ENABLE     = 8'h14;
    localparam logic [7:0] OFS_CHAN_CTRL       = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS      = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK        = 8'h20;
    localparam logic [7:0] OFS_CHIP_IRQ_MASK   = 8'h24;
    localparam logic [7:0] OFS_CHIP_IRQ_STATUS = 8'h28;
    // ==========================================================
    // out_port_config fields
    localparam int CFG_OUT2_LSB = 0;
    localparam int CFG_OUT3_LSB = 2;
    localparam int CFG_OUT4_BIT = 4;
    localparam int CFG_OUT5_BIT = 5;
    localparam int CFG_OUT6_BIT = 6;
    localparam int CFG_OUT7_BIT = 7;
    // function enable fields
    localparam int FE_RTS_A       = 0;
    localparam int FE_RTS_B       = 1;
    localparam int FE_CTS_A       = 2;
    localparam int FE_CTS_B       = 3;
    localparam int FE_CT_EXT      = 4;
    localparam int FE_TXCLK_A     = 5;
    localparam int FE_RXCLK_A     = 6;
    localparam int FE_TXCLK_B     = 7;
    localparam int FE_RXCLK_B     = 8;
    localparam int FE_RXFULL_SEL_A = 9;
    localparam int FE_RXFULL_SEL_B = 10;
    // channel control fields
    localparam int CC_TX_EN_A = 0;
    localparam int CC_TX_EN_B = 1;
    localparam int CC_LOOP_A  = 2;
    localparam int CC_LOOP_B  = 3;
    // interrupt status bits (events of this block)
    localparam int IRQ_CTS_A_CHG  = 0;
    localparam int IRQ_CTS_B_CHG  = 1;
    localparam int IRQ_CT_EXT_EDG = 2;
    localparam int IRQ_RX_A_START = 3;
    localparam int IRQ_RX_B_START = 4;
    localparam int IRQ_WIDTH      = 5;
    // ==========================================================
    // values after reset
    localparam logic [7:0]  RST_OUT_PORT_CONFIG = 8'h00;
    localparam logic [7:0]  RST_OUT_PORT_DATA   = 8'h00;
    localparam logic [10:0] RST_FUNC_ENABLE     = 11'h000;
    localparam logic [3:0]  RST_CHAN_CTRL       = 4'h0;
    localparam logic [7:0]  RST_CHIP_IRQ_MASK   = 8'h00;
    localparam logic [4:0]  RST_IRQ_MASK        = 5'h00;
    // ==========================================================
    // out two / out three selector codes
    localparam logic [1:0] SEL_GP     = 2'h0;
    localparam logic [1:0] SEL_ALT1   = 2'h1;
    localparam logic [1:0] SEL_ALT2   = 2'h2;
    localparam logic [1:0] SEL_ALT3   = 2'h3;
endpackage

// file: design/dupf_top.sv
// pin function logic of a dual asynchronous serial controller
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ns
// Operation
// - transmit held at mark: reset, loopback, disabled
// - receive high is mark one, low space
// - high reset returns everything to initial state
// - transmit and receive disabled during reset
// - out zero/one: general or request-to-send
// - out two: config bits 1:0 pick clocks
// - out three: config bits 3:2 pick function
// - out four: bit 4, channel A ready/full
// - out five: bit 5, channel B ready/full
// - out six/seven: general or holding-empty flag
// - shared interrupt open-drain, any enabled condition
// - in zero/one: general or clear-to-send
// - in two: general or counter external clock
// - in three/five: transmit clocks, falling edge
// - in four/six: receive clocks, rising edge
// - serial bits least significant first
module dupf_top
    import dupf_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // serial lines
    input  wire logic        serial_in_a_i,
    input  wire logic        serial_in_b_i,
    output logic             serial_out_a_o,
    output logic             serial_out_b_o,
    // internal datapath side
    input  wire logic        tx_data_a_i,
    input  wire logic        tx_data_b_i,
    output logic             rx_data_a_o,
    output logic             rx_data_b_o,
    input  wire logic        request_send_a_n_i,
    input  wire logic        request_send_b_n_i,
    input  wire logic        tx_a_clock_x1_i,
    input  wire logic        tx_a_clock_x16_i,
    input  wire logic        rx_a_clock_x1_i,
    input  wire logic        tx_b_clock_x1_i,
    input  wire logic        rx_b_clock_x1_i,
    input  wire logic        ct_out_i,
    input  wire logic        rx_a_ready_i,
    input  wire logic        rx_a_fifo_full_i,
    input  wire logic        rx_b_ready_i,
    input  wire logic        rx_b_fifo_full_i,
    input  wire logic        tx_a_hold_empty_i,
    input  wire logic        tx_b_hold_empty_i,
    input  wire logic [7:0]  chip_irq_cond_i,
    // multipurpose pins
    input  wire logic [6:0]  mp_in_i,
    output logic      [7:0]  mp_out_o,
    output logic      [7:0]  mp_out_oe_o,
    output logic             irq_n_o,
    output logic             irq_n_oe_o,
    output logic             irq_o,
    // decoded alternate input functions
    output logic             clear_send_a_n_o,
    output logic             clear_send_b_n_o,
    output logic             ct_ext_clk_o,
    output logic             tx_clk_fall_a_o,
    output logic             tx_clk_fall_b_o,
    output logic             rx_clk_rise_a_o,
    output logic             rx_clk_rise_b_o
);
    import dupf_pkg::*;

    // ==========================================================
    // registers
    logic [7:0]           out_port_config;
    logic [7:0]           out_port_data;
    logic [10:0]          func_enable;
    logic [3:0]           chan_ctrl;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [7:0]           chip_irq_mask;
    logic [6:0]           mp_in_q;
    logic [IRQ_WIDTH-1:0] next_events;
    logic [7:0]           next_mp_out;
    logic [7:0]           next_mp_oe;
    logic                 next_chip_irq;
    logic [31:0]          next_rdata;
    logic                 bus_req;
    logic                 wr_hit;
    logic                 rx_a_idle_q;
    logic                 rx_b_idle_q;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_hit  = bus_req && wb_we_i && wb_sel_i[0];

    // ==========================================================
    // wishbone answer: one wait state, ack dropped after one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            OFS_OUT_PORT_CONFIG: next_rdata[7:0]  = out_port_config;
            OFS_OUT_PORT_DATA:   next_rdata[7:0]  = out_port_data;
            // input bits read as the pin complement
            OFS_IN_PORT:         next_rdata[6:0]  = ~mp_in_q;
            OFS_FUNC_ENABLE:     next_rdata[10:0] = func_enable;
            OFS_CHAN_CTRL:       next_rdata[3:0]  = chan_ctrl;
            OFS_IRQ_STATUS:      next_rdata[4:0]  = irq_status;
            OFS_IRQ_MASK:        next_rdata[4:0]  = irq_mask;
            OFS_CHIP_IRQ_MASK:   next_rdata[7:0]  = chip_irq_mask;
            OFS_CHIP_IRQ_STATUS: next_rdata[7:0]  = chip_irq_cond_i;
            default:             next_rdata       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i && bus_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_port_config <= RST_OUT_PORT_CONFIG;
            out_port_data   <= RST_OUT_PORT_DATA;
            chan_ctrl       <= RST_CHAN_CTRL;
            irq_mask        <= RST_IRQ_MASK;
            chip_irq_mask   <= RST_CHIP_IRQ_MASK;
        end else if (ce_i && wr_hit) begin
            unique case (wb_adr_i)
                OFS_OUT_PORT_CONFIG: out_port_config <= wb_dat_i[7:0];
                OFS_OUT_PORT_DATA:   out_port_data   <= wb_dat_i[7:0];
                OFS_OUT_PORT_SET:
                    out_port_data <= out_port_data | wb_dat_i[7:0];
                OFS_OUT_PORT_CLEAR:
                    out_port_data <= out_port_data & ~wb_dat_i[7:0];
                OFS_CHAN_CTRL:       chan_ctrl     <= wb_dat_i[3:0];
                OFS_IRQ_MASK:        irq_mask      <= wb_dat_i[4:0];
                OFS_CHIP_IRQ_MASK:   chip_irq_mask <= wb_dat_i[7:0];
                default:             ;
            endcase
        end
    end

    // function enable spans two byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            func_enable <= RST_FUNC_ENABLE;
        end else if (ce_i && bus_req && wb_we_i
                     && wb_adr_i == OFS_FUNC_ENABLE) begin
            if (wb_sel_i[0]) begin
                func_enable[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                func_enable[10:8] <= wb_dat_i[10:8];
            end
        end
    end

    // ==========================================================
    // input sampling and events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mp_in_q     <= 7'h7f;
            rx_a_idle_q <= 1'b1;
            rx_b_idle_q <= 1'b1;
        end else if (ce_i) begin
            mp_in_q     <= mp_in_i;
            rx_a_idle_q <= serial_in_a_i;
            rx_b_idle_q <= serial_in_b_i;
        end
    end

    always_comb begin
        next_events = '0;
        next_events[IRQ_CTS_A_CHG] = func_enable[FE_CTS_A]
            && (mp_in_i[0] != mp_in_q[0]);
        next_events[IRQ_CTS_B_CHG] = func_enable[FE_CTS_B]
            && (mp_in_i[1] != mp_in_q[1]);
        next_events[IRQ_CT_EXT_EDG] = func_enable[FE_CT_EXT]
            && mp_in_i[2] && !mp_in_q[2];
        // a space after idle mark is a start bit
        next_events[IRQ_RX_A_START] = rx_a_idle_q && !serial_in_a_i;
        next_events[IRQ_RX_B_START] = rx_b_idle_q && !serial_in_b_i;
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= '0;
        end else if (ce_i) begin
            if (wr_hit && wb_adr_i == OFS_IRQ_STATUS) begin
                irq_status <= (irq_status & ~wb_dat_i[4:0]) | next_events;
            end else begin
                irq_status <= irq_status | next_events;
            end
        end
    end

    // ==========================================================
    // alternate input decode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_send_a_n_o <= 1'b1;
            clear_send_b_n_o <= 1'b1;
            ct_ext_clk_o     <= 1'b0;
            tx_clk_fall_a_o  <= 1'b0;
            tx_clk_fall_b_o  <= 1'b0;
            rx_clk_rise_a_o  <= 1'b0;
            rx_clk_rise_b_o  <= 1'b0;
        end else if (ce_i) begin
            clear_send_a_n_o <= func_enable[FE_CTS_A] ? mp_in_q[0] : 1'b1;
            clear_send_b_n_o <= func_enable[FE_CTS_B] ? mp_in_q[1] : 1'b1;
            ct_ext_clk_o     <= func_enable[FE_CT_EXT] && mp_in_q[2];
            // strobes on the edge each clock shifts on
            tx_clk_fall_a_o <= func_enable[FE_TXCLK_A]
                && mp_in_q[3] && !mp_in_i[3];
            tx_clk_fall_b_o <= func_enable[FE_TXCLK_B]
                && mp_in_q[5] && !mp_in_i[5];
            rx_clk_rise_a_o <= func_enable[FE_RXCLK_A]
                && !mp_in_q[4] && mp_in_i[4];
            rx_clk_rise_b_o <= func_enable[FE_RXCLK_B]
                && !mp_in_q[6] && mp_in_i[6];
        end
    end

    // ==========================================================
    // serial lines; datapath shifts lsb first, we pass bits in order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_out_a_o <= 1'b1;
            serial_out_b_o <= 1'b1;
            rx_data_a_o    <= 1'b1;
            rx_data_b_o    <= 1'b1;
        end else if (ce_i) begin
            serial_out_a_o <= (chan_ctrl[CC_TX_EN_A] && !chan_ctrl[CC_LOOP_A])
                ? tx_data_a_i : 1'b1;
            serial_out_b_o <= (chan_ctrl[CC_TX_EN_B] && !chan_ctrl[CC_LOOP_B])
                ? tx_data_b_i : 1'b1;
            // local loop feeds the receiver from its own transmitter
            rx_data_a_o <= chan_ctrl[CC_LOOP_A]
                ? tx_data_a_i : serial_in_a_i;
            rx_data_b_o <= chan_ctrl[CC_LOOP_B]
                ? tx_data_b_i : serial_in_b_i;
        end
    end

    // ==========================================================
    // multipurpose output mux; general bits drive pin as complement
    always_comb begin
        next_mp_out = ~out_port_data;
        next_mp_oe  = 8'hff;
        if (func_enable[FE_RTS_A]) begin
            next_mp_out[0] = request_send_a_n_i;
        end
        if (func_enable[FE_RTS_B]) begin
            next_mp_out[1] = request_send_b_n_i;
        end
        unique case (out_port_config[CFG_OUT2_LSB +: 2])
            SEL_ALT1: next_mp_out[2] = tx_a_clock_x1_i;
            SEL_ALT2: next_mp_out[2] = tx_a_clock_x16_i;
            SEL_ALT3: next_mp_out[2] = rx_a_clock_x1_i;
            default:  ;
        endcase
        unique case (out_port_config[CFG_OUT3_LSB +: 2])
            SEL_ALT1: begin
                next_mp_out[3] = 1'b0;
                next_mp_oe[3]  = !ct_out_i;
            end
            SEL_ALT2: next_mp_out[3] = tx_b_clock_x1_i;
            SEL_ALT3: next_mp_out[3] = rx_b_clock_x1_i;
            default:  ;
        endcase
        if (out_port_config[CFG_OUT4_BIT]) begin
            next_mp_out[4] = 1'b0;
            next_mp_oe[4]  = func_enable[FE_RXFULL_SEL_A]
                ? rx_a_fifo_full_i : rx_a_ready_i;
        end
        if (out_port_config[CFG_OUT5_BIT]) begin
            next_mp_out[5] = 1'b0;
            next_mp_oe[5]  = func_enable[FE_RXFULL_SEL_B]
                ? rx_b_fifo_full_i : rx_b_ready_i;
        end
        if (out_port_config[CFG_OUT6_BIT]) begin
            next_mp_out[6] = 1'b0;
            next_mp_oe[6]  = tx_a_hold_empty_i;
        end
        if (out_port_config[CFG_OUT7_BIT]) begin
            next_mp_out[7] = 1'b0;
            next_mp_oe[7]  = tx_b_hold_empty_i;
        end
    end

    assign next_chip_irq = |(chip_irq_cond_i & chip_irq_mask)
                           || |(irq_status & irq_mask);

    // ==========================================================
    // registered pins, all from the oscillator clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mp_out_o    <= 8'hff;
            mp_out_oe_o <= 8'hff;
            irq_n_o     <= 1'b0;
            irq_n_oe_o  <= 1'b0;
            irq_o       <= 1'b0;
        end else if (ce_i) begin
            mp_out_o    <= next_mp_out;
            mp_out_oe_o <= next_mp_oe;
            irq_n_o     <= 1'b0;
            irq_n_oe_o  <= next_chip_irq;
            irq_o       <= next_chip_irq;
        end
    end
endmodule

// file: tb/dupf_peer.sv
// remote serial peer: idle at mark, sends one framed byte on request
`timescale 1ns/1ns
module dupf_peer #(
    parameter int         BIT_CYC = 4,
    parameter logic [7:0] BYTE    = 8'ha5
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] send_i,
    output logic            serial_a_o,
    output logic            serial_b_o
);
    logic [9:0] sh  [2];
    int         cnt [2];
    always_ff @(posedge clk_i) begin
        for (int c = 0; c < 2; c++) begin
            if (rst_i) begin
                sh[c]  <= 10'h3ff;
                cnt[c] <= 0;
            end else if (send_i[c] && cnt[c] == 0) begin
                sh[c]  <= {1'b1, BYTE, 1'b0};
                cnt[c] <= 10 * BIT_CYC;
            end else if (cnt[c] != 0) begin
                cnt[c] <= cnt[c] - 1;
                if (cnt[c] % BIT_CYC == 1) sh[c] <= {1'b1, sh[c][9:1]};
            end
        end
    end
    // stop bit refill keeps the line at mark between frames
    assign serial_a_o = sh[0][0];
    assign serial_b_o = sh[1][0];
endmodule

// file: tb/dupf_top_asserts.sv
// concurrent checks on the ports of the pin function block
`timescale 1ns/1ns
module dupf_top_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        serial_out_a_o,
    input wire logic        serial_out_b_o,
    input wire logic [7:0]  mp_out_o,
    input wire logic [7:0]  mp_out_oe_o,
    input wire logic        irq_n_o,
    input wire logic        irq_n_oe_o,
    input wire logic        irq_o,
    input wire logic        clear_send_a_n_o,
    input wire logic        tx_clk_fall_a_o,
    input wire logic        rx_clk_rise_a_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    // ==========================================================
    // reset behaviour: no disable, reset is the cause here
    property p_rst_lines;
        rst_i && ce_i |=> serial_out_a_o && serial_out_b_o;
    endproperty
    a_rst_lines: assert property (p_rst_lines)
        else $error("transmit lines not at mark after reset");
    property p_rst_pins;
        rst_i && ce_i |=> mp_out_o == 8'hff && mp_out_oe_o == 8'hff
            && !irq_o && !irq_n_oe_o && clear_send_a_n_o
            && !wb_ack_o && wb_dat_o == 32'h0;
    endproperty
    a_rst_pins: assert property (p_rst_pins)
        else $error("outputs not at initial state after reset");
    // ==========================================================
    // bus answer, interrupt pin and clock edge strobes
    property p_ack_resp;
        disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("bus request not answered next cycle");
    property p_ack_pulse;
        disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge longer than one cycle");
    property p_irq_pin;
        disable iff (rst_i) irq_n_oe_o == irq_o;
    endproperty
    a_irq_pin: assert property (p_irq_pin)
        else $error("interrupt pin enable differs from level");
    property p_irq_od;
        disable iff (rst_i) !irq_n_o;
    endproperty
    a_irq_od: assert property (p_irq_od)
        else $error("open-drain interrupt drives high");
    property p_txfall;
        disable iff (rst_i) tx_clk_fall_a_o |=> !tx_clk_fall_a_o;
    endproperty
    a_txfall: assert property (p_txfall)
        else $error("transmit clock edge pulse too long");
    property p_rxrise;
        disable iff (rst_i) rx_clk_rise_a_o |=> !rx_clk_rise_a_o;
    endproperty
    a_rxrise: assert property (p_rxrise)
        else $error("receive clock edge pulse too long");
    c_ack: cover property (wb_ack_o);
    c_irq: cover property ($rose(irq_o));
    c_txfall: cover property (tx_clk_fall_a_o);
    c_rxrise: cover property (rx_clk_rise_a_o);
endmodule
bind dupf_top dupf_top_asserts dupf_top_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_out_a_o(serial_out_a_o), .serial_out_b_o(serial_out_b_o),
    .mp_out_o(mp_out_o), .mp_out_oe_o(mp_out_oe_o), .irq_n_o(irq_n_o),
    .irq_n_oe_o(irq_n_oe_o), .irq_o(irq_o),
    .clear_send_a_n_o(clear_send_a_n_o),
    .tx_clk_fall_a_o(tx_clk_fall_a_o), .rx_clk_rise_a_o(rx_clk_rise_a_o));

// file: tb/testbench.sv
// self-checking bench for the pin function block
`timescale 1ns/1ns
module testbench;
    import dupf_pkg::*;
    // ==========================================================
    // signals
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic        wb_ack_o, serial_in_a_i, serial_in_b_i;
    logic        serial_out_a_o, serial_out_b_o, rx_data_a_o, rx_data_b_o;
    logic        tx_data_a_i = 1'b1, tx_data_b_i = 1'b1;
    logic        request_send_a_n_i = 1'b1, request_send_b_n_i = 1'b1;
    logic [2:0]  mon_a = 3'h0, mon_b = 3'h0;
    logic [5:0]  flg = 6'h00;
    logic [7:0]  chip_irq_cond_i = 8'h00, mp_out_o, mp_out_oe_o;
    logic [6:0]  mp_in_i = 7'h00;
    logic        irq_n_o, irq_n_oe_o, irq_o, ct_ext_clk_o;
    logic        clear_send_a_n_o, clear_send_b_n_o;
    logic        tx_clk_fall_a_o, tx_clk_fall_b_o;
    logic        rx_clk_rise_a_o, rx_clk_rise_b_o;
    logic [1:0]  send = 2'h0;
    logic [7:0]  pulses [4];
    logic [7:0]  byte_seen;
    int          errors = 0, check_count = 0, cycles = 0;
    wire tx_a_clock_x1_i = mon_a[0], tx_a_clock_x16_i = mon_a[1];
    wire rx_a_clock_x1_i = mon_a[2], ct_out_i = mon_b[0];
    wire tx_b_clock_x1_i = mon_b[1], rx_b_clock_x1_i = mon_b[2];
    wire rx_a_ready_i = flg[0], rx_a_fifo_full_i = flg[1];
    wire rx_b_ready_i = flg[2], rx_b_fifo_full_i = flg[3];
    wire tx_a_hold_empty_i = flg[4], tx_b_hold_empty_i = flg[5];
    dupf_top dupf_top_inst (.*);
    dupf_peer #(.BIT_CYC(4), .BYTE(8'ha5)) dupf_peer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .send_i(send),
        .serial_a_o(serial_in_a_i), .serial_b_o(serial_in_b_i));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        pulses[0] <= rst_i ? 8'h0 : pulses[0] + {7'h0, tx_clk_fall_a_o};
        pulses[1] <= rst_i ? 8'h0 : pulses[1] + {7'h0, tx_clk_fall_b_o};
        pulses[2] <= rst_i ? 8'h0 : pulses[2] + {7'h0, rx_clk_rise_a_o};
        pulses[3] <= rst_i ? 8'h0 : pulses[3] + {7'h0, rx_clk_rise_b_o};
        if (cycles == 4000) begin
            errors = errors + 1;
            end_sim();
        end
    end
    // ==========================================================
    // tasks
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; request held until ack is sampled
    task automatic xfer(input logic we, input logic [7:0] a,
                        input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        @(posedge clk_i);
        // a missing ack is caught by the bench timeout, never let through
        while (wb_ack_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rdat, exp);
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // sequence
    initial begin
        wt(4);
        rst_i <= 1'b0;
        wt(1);
        check(32'({serial_out_a_o, serial_out_b_o, rx_data_a_o,
                   rx_data_b_o}), 32'hf);
        check(32'({mp_out_o, mp_out_oe_o}), 32'hffff);
        rdchk(OFS_IRQ_STATUS, 32'h0);
        $display("test reset done");
        xfer(1'b1, OFS_CHAN_CTRL, 32'h3);
        tx_data_a_i <= 1'b0;
        tx_data_b_i <= 1'b0;
        wt(2);
        check(32'({serial_out_a_o, serial_out_b_o}), 32'h0);
        xfer(1'b1, OFS_CHAN_CTRL, 32'hf);
        check(32'({serial_out_a_o, rx_data_a_o, serial_out_b_o,
                   rx_data_b_o}), 32'ha);
        xfer(1'b1, OFS_CHAN_CTRL, 32'h2);
        check(32'(serial_out_a_o), 32'h1);
        tx_data_a_i <= 1'b1;
        send <= 2'h1;
        wt(1);
        send <= 2'h0;
        for (int i = 0; i < 20 && rx_data_a_o !== 1'b0; i++) wt(1);
        wt(2);
        for (int i = 0; i < 8; i++) begin
            wt(4);
            byte_seen[i] = rx_data_a_o;
        end
        check(32'(byte_seen), 32'ha5);
        wt(12);
        rdchk(OFS_IRQ_STATUS, 32'h08);
        xfer(1'b1, OFS_IRQ_STATUS, 32'h08);
        rdchk(OFS_IRQ_STATUS, 32'h0);
        $display("test serial lines done");
        xfer(1'b1, OFS_OUT_PORT_DATA, 32'h5a);
        check(32'({mp_out_o, mp_out_oe_o}), 32'ha5ff);
        xfer(1'b1, OFS_OUT_PORT_SET, 32'h81);
        check(32'(mp_out_o), 32'h24);
        xfer(1'b1, OFS_OUT_PORT_CLEAR, 32'h42);
        check(32'(mp_out_o), 32'h66);
        xfer(1'b1, OFS_FUNC_ENABLE, 32'h3);
        request_send_b_n_i <= 1'b0;
        wt(2);
        check(32'(mp_out_o[1:0]), 32'h1);
        $display("test general outputs done");
        // selected source opposite to the others, both polarities
        for (int s = 1; s < 4; s++) begin
            xfer(1'b1, OFS_OUT_PORT_CONFIG, 32'(s * 5));
            for (int p = 0; p < 2; p++) begin
                mon_a <= (p == 1 ? 3'h0 : 3'h7) ^ (3'h1 << (s - 1));
                mon_b <= (p == 1 ? 3'h0 : 3'h7) ^ (3'h1 << (s - 1));
                wt(2);
                check(32'(mp_out_o[2]), 32'(p));
                if (s == 1) check(32'(mp_out_oe_o[3]), 32'(1 - p));
                else check(32'(mp_out_o[3]), 32'(p));
            end
        end
        xfer(1'b1, OFS_OUT_PORT_CONFIG, 32'hf0);
        xfer(1'b1, OFS_FUNC_ENABLE, 32'h400);
        for (int p = 0; p < 2; p++) begin
            flg <= p == 1 ? 6'h16 : 6'h29;
            wt(2);
            check(32'({mp_out_oe_o[7:4], mp_out_o[7:4]}),
                  p == 1 ? 32'h40 : 32'hb0);
        end
        $display("test output functions done");
        xfer(1'b1, OFS_CHIP_IRQ_MASK, 32'h10);
        chip_irq_cond_i <= 8'h21;
        wt(3);
        check(32'({irq_o, irq_n_oe_o, irq_n_o}), 32'h0);
        rdchk(OFS_CHIP_IRQ_STATUS, 32'h21);
        chip_irq_cond_i <= 8'h31;
        wt(3);
        check(32'({irq_o, irq_n_oe_o, irq_n_o}), 32'h6);
        chip_irq_cond_i <= 8'h00;
        xfer(1'b1, OFS_FUNC_ENABLE, 32'h1fc);
        xfer(1'b1, OFS_IRQ_STATUS, 32'h1f);
        mp_in_i <= 7'h05;
        wt(4);
        check(32'({clear_send_a_n_o, clear_send_b_n_o, ct_ext_clk_o}),
              32'h5);
        rdchk(OFS_IRQ_STATUS, 32'h05);
        check(32'(irq_o), 32'h0);
        xfer(1'b1, OFS_IRQ_MASK, 32'h04);
        wt(2);
        check(32'(irq_o), 32'h1);
        xfer(1'b1, OFS_IRQ_STATUS, 32'h04);
        wt(2);
        check(32'(irq_o), 32'h0);
        rdchk(OFS_IRQ_STATUS, 32'h01);
        mp_in_i <= 7'h7d;
        wt(3);
        mp_in_i <= 7'h05;
        wt(4);
        check({pulses[0], pulses[1], pulses[2], pulses[3]},
              32'h01010101);
        rdchk(OFS_IN_PORT, 32'h7a);
        xfer(1'b1, 8'h30, 32'hffff);
        rdchk(8'h30, 32'h0);
        $display("test interrupts and inputs done");
        rst_i <= 1'b1;
        wt(2);
        rst_i <= 1'b0;
        wt(1);
        check(32'({mp_out_o, mp_out_oe_o}), 32'hffff);
        check(32'(serial_out_b_o), 32'h1);
        rdchk(OFS_IRQ_STATUS, 32'h0);
        rdchk(OFS_FUNC_ENABLE, 32'h0);
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
